// [global_pin0_config.sv]
`timescale 1ns/10ps
`include "global_pin0_consts.svh"

// level filter: a new level is taken once it has held for limit ticks
module level_debounce (
   input wire logic core_clk, // system clock
   input wire logic sys_rst, // sync reset
   input wire logic tick, // base tick enable
   input wire logic bypass, // take level at once
   input wire logic [`TIMER_W-1:0] limit, // ticks to hold
   input wire logic level_in, // synchronised level
   output logic level_out // filtered level
);
   logic [`TIMER_W-1:0] cnt_reg;
   // any bounce restarts the count
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         level_out <= 1'b1;
      end else if (bypass || level_in == level_out) begin
         cnt_reg <= '0;
         level_out <= level_in;
      end else if (tick) begin
         if (cnt_reg >= limit - `TIMER_W'(1)) begin
            cnt_reg <= '0;
            level_out <= level_in;
         end else begin
            cnt_reg <= cnt_reg + `TIMER_W'(1);
         end
      end
   end
endmodule : level_debounce

module global_pin0_config
   import global_pin0_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `RST_DEV_ADDR, // serial address, arbitrary value
   parameter logic [`TIMER_W-1:0] ONKEY_DEB_SHORT = `TIMER_W'(`US_TO_TICKS(`T_ONKEY_DEB_SHORT_US)),
   parameter logic [`TIMER_W-1:0] DEB_LONG = `TIMER_W'(`US_TO_TICKS(`T_DEB_LONG_US)),
   parameter logic [`TIMER_W-1:0] MRST_SHORT = `TIMER_W'(`US_TO_TICKS(`T_KEYHOLD_SHORT_US)),
   parameter logic [`TIMER_W-1:0] MRST_LONG = `TIMER_W'(`US_TO_TICKS(`T_KEYHOLD_LONG_US)),
   parameter logic [`TIMER_W-1:0] PD_INIT_TICKS = `TIMER_W'(`US_TO_TICKS(`T_PD_INIT_US)),
   parameter logic [`TIMER_W-1:0] PD_RST_TICKS = `TIMER_W'(`US_TO_TICKS(`T_PD_RST_US)),
   parameter logic [`TIMER_W-1:0] PD_SLOT_TICKS = `TIMER_W'(`US_TO_TICKS(`T_PD_SLOT_US)),
   parameter logic [`TIMER_W-1:0] PD_DISCH_TICKS = `TIMER_W'(`US_TO_TICKS(`T_PD_DISCHARGE_US))
) (
   input wire logic core_clk, // 100 MHz clock
   input wire logic sys_rst, // sync reset, high
   input wire logic scl_in, // serial clock pin
   input wire logic sda_in, // serial data pin level
   output logic sda_out, // serial data drive value
   output logic sda_oe, // serial data pull low
   input wire factory_t factory_cfg, // factory reset values
   input wire logic onkey_input, // on-key pin, active low
   output logic onkey_pullup_weak, // weak pull-up select
   output logic onkey_style_slide, // slide-switch mode
   output logic onkey_active, // debounced on-key active
   output logic manual_reset_request, // held-key reset pulse
   input wire logic onoff_bias_request, // controller bias request
   output logic main_bias_enable, // bias on
   output logic main_bias_lowpower, // bias low-power request
   input wire logic wake_event, // wake after power off
   input wire logic ship_exit_event, // leave factory ship
   output logic reset_output_low, // reset output, low active
   output logic regulators_on, // rails enabled
   output logic output_discharge, // rail discharge active
   output logic battery_switch_open, // battery switch opened
   input wire logic buck_boost_rail_two, // sequencer enable for rail two
   input wire logic pin0_in, // pin 0 level
   output logic pin0_out, // pin 0 drive value
   output logic pin0_oe, // pin 0 driven
   output logic pin0_level // debounced pin 0 level
);
   localparam int TICK_LAST = `TICK_CYCLES - 1;
   global_cfg_t glb_reg;
   pin_cfg_t pin_reg;
   pd_state_t pd_state;
   bus_state_t bus_state;
   logic [9:0] tick_cnt_reg;
   logic tick;
   logic cfg_reset;
   logic [`TIMER_W-1:0] pd_cnt_reg, pd_limit, mrst_cnt_reg;
   logic [1:0] slot_reg;
   power_cmd_t pd_cmd_reg;
   logic onkey_m, onkey_s, onkey_level, mrst_fired;
   logic pin_m, pin_s;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic [3:0] bit_cnt;
   logic [7:0] shift_reg, ptr_reg, wr_data, rd_byte;
   logic [`ADDR_WIDTH-1:0] wr_addr;
   logic ack_phase, wr_en;
   logic pd_done;

   // base tick; every long time counts these
   always_ff @(posedge core_clk) begin
      if (sys_rst || tick_cnt_reg == 10'(TICK_LAST)) tick_cnt_reg <= '0;
      else tick_cnt_reg <= tick_cnt_reg + 10'd1;
      tick <= !sys_rst && tick_cnt_reg == 10'(TICK_LAST);
   end

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         {onkey_m, onkey_s, pin_m, pin_s} <= 4'hf;
         {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
      end else begin
         onkey_m <= onkey_input;
         onkey_s <= onkey_m;
         pin_m <= pin0_in;
         pin_s <= pin_m;
         {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      end
   end

   level_debounce onkey_filter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .bypass(1'b0),
      .limit(glb_reg.onkey_debounce_select ? DEB_LONG : ONKEY_DEB_SHORT),
      .level_in(onkey_s),
      .level_out(onkey_level)
   );
   level_debounce pin_filter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .bypass(!pin_reg.pin_input_debounce_enable),
      .limit(DEB_LONG),
      .level_in(pin_s),
      .level_out(pin0_level)
   );

   // key status, bias and pull-up outputs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         onkey_active <= 1'b0;
         main_bias_enable <= 1'b0;
      end else begin
         onkey_active <= !onkey_level;
         main_bias_enable <= glb_reg.main_bias_force_on | onoff_bias_request;
      end
   end
   assign onkey_pullup_weak = glb_reg.onkey_pullup_weak_select;
   assign onkey_style_slide = glb_reg.onkey_input_style;
   assign main_bias_lowpower = glb_reg.main_bias_lowpower_request;

   // held key raises one reset pulse per press
   always_ff @(posedge core_clk) begin
      if (sys_rst || !onkey_active) begin
         mrst_cnt_reg <= '0;
         mrst_fired <= 1'b0;
         manual_reset_request <= 1'b0;
      end else begin
         manual_reset_request <= 1'b0;
         if (tick && !mrst_fired) begin
            if (mrst_cnt_reg >= (glb_reg.manual_reset_duration_select ? MRST_LONG : MRST_SHORT) - `TIMER_W'(1)) begin
               mrst_fired <= 1'b1;
               manual_reset_request <= 1'b1;
            end else begin
               mrst_cnt_reg <= mrst_cnt_reg + `TIMER_W'(1);
            end
         end
      end
   end

   // register file; factory fields reload at every config reset
   always_ff @(posedge core_clk) begin
      if (sys_rst || cfg_reset) begin
         glb_reg <= '{`RST_PULLUP_WEAK, factory_cfg.manual_reset_duration_select,
                      factory_cfg.main_bias_lowpower_request, `RST_BIAS_FORCE, factory_cfg.onkey_input_style,
                      factory_cfg.onkey_debounce_select, `RST_POWER_CMD};
         pin_reg <= '{2'b00, factory_cfg.pin0_alternate_function, `RST_PIN_DEB, `RST_PIN_DOUT,
                      `RST_PIN_DRIVER, 1'b0, `RST_PIN_DIR_INPUT};
      end else if (wr_en && wr_addr == `ADDR_GLOBAL_CONFIG) begin
         glb_reg <= wr_data;
      end else if (wr_en && wr_addr == `ADDR_PIN0_CONFIG) begin
         pin_reg <= wr_data & `PIN_RSVD_MASK; // reserved and read-only bits not stored
      end
   end

   // read view; live pin level replaces the stored input bit
   always_comb begin
      rd_byte = 8'h00;
      if (ptr_reg == `ADDR_GLOBAL_CONFIG) rd_byte = glb_reg;
      if (ptr_reg == `ADDR_PIN0_CONFIG) begin
         rd_byte = pin_reg;
         rd_byte[`PIN_DIN_BIT] = pin_s;
      end
   end

   // pin 0 drive
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin0_out <= 1'b0;
         pin0_oe <= 1'b0;
      end else if (pin_reg.pin0_alternate_function) begin
         pin0_out <= buck_boost_rail_two;
         pin0_oe <= 1'b1;
      end else if (pin_reg.pin_direction_input) begin
         pin0_out <= 1'b0;
         pin0_oe <= 1'b0;
      end else begin
         pin0_out <= pin_reg.pin_output_value;
         pin0_oe <= !pin_reg.pin_output_value || pin_reg.pin_driver_type;
      end
   end

   // power-down timing; the host waits out the whole run
   always_comb begin
      unique case (pd_state)
         PD_INIT: pd_limit = PD_INIT_TICKS;
         PD_RST: pd_limit = PD_RST_TICKS;
         PD_SLOT: pd_limit = PD_SLOT_TICKS;
         default: pd_limit = PD_DISCH_TICKS;
      endcase
      pd_done = tick && pd_cnt_reg >= pd_limit - `TIMER_W'(1);
   end

   // power command sequencer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pd_state <= PD_IDLE;
         pd_cmd_reg <= CMD_NONE;
         pd_cnt_reg <= '0;
         slot_reg <= '0;
         cfg_reset <= 1'b0;
         reset_output_low <= 1'b1;
         regulators_on <= 1'b1;
         output_discharge <= 1'b0;
         battery_switch_open <= 1'b0;
      end else begin
         cfg_reset <= 1'b0;
         if (pd_state inside {PD_INIT, PD_RST, PD_SLOT, PD_DISCHARGE})
            pd_cnt_reg <= pd_done ? '0 : pd_cnt_reg + `TIMER_W'(tick);
         unique case (pd_state)
            PD_IDLE: begin
               if (wr_en && wr_addr == `ADDR_GLOBAL_CONFIG) begin
                  pd_cmd_reg <= power_cmd_t'(wr_data[1:0]);
                  pd_cnt_reg <= '0;
                  if (wr_data[1:0] == CMD_COLD_RESTART || wr_data[1:0] == CMD_POWER_OFF)
                     pd_state <= PD_INIT; // code zero stays idle
                  else if (wr_data[1:0] == CMD_FACTORY_SHIP) begin
                     pd_state <= PD_SHIP;
                     cfg_reset <= 1'b1;
                     regulators_on <= 1'b0;
                     reset_output_low <= 1'b0;
                     battery_switch_open <= 1'b1;
                  end
               end
            end
            PD_INIT: if (pd_done) begin
               pd_state <= PD_RST;
               reset_output_low <= 1'b0;
            end
            PD_RST: if (pd_done) begin
               pd_state <= PD_SLOT;
               slot_reg <= '0;
               regulators_on <= 1'b0;
            end
            PD_SLOT: if (pd_done) begin
               slot_reg <= slot_reg + 2'd1;
               if (slot_reg == 2'(`PD_SLOT_COUNT - 1)) begin
                  pd_state <= PD_DISCHARGE;
                  output_discharge <= 1'b1;
               end
            end
            PD_DISCHARGE: if (pd_done) begin
               output_discharge <= 1'b0;
               cfg_reset <= 1'b1;
               if (pd_cmd_reg == CMD_COLD_RESTART) begin
                  pd_state <= PD_IDLE;
                  regulators_on <= 1'b1;
                  reset_output_low <= 1'b1;
               end else begin
                  pd_state <= PD_OFF;
               end
            end
            PD_OFF: if (wake_event) begin
               pd_state <= PD_IDLE;
               regulators_on <= 1'b1;
               reset_output_low <= 1'b1;
            end
            PD_SHIP: if (ship_exit_event) begin
               pd_state <= PD_IDLE;
               regulators_on <= 1'b1;
               reset_output_low <= 1'b1;
               battery_switch_open <= 1'b0;
            end
         endcase
      end
   end

   // serial bus slave: address, pointer, then data with auto-increment
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign bus_start = scl_s && scl_d && sda_d && !sda_s;
   assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
   assign sda_out = 1'b0; // open drain: only ever pulls low
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus_state <= BUS_IDLE;
         {bit_cnt, shift_reg, ptr_reg, ack_phase, sda_oe, wr_en} <= '0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         wr_en <= 1'b0;
         if (bus_start) begin
            bus_state <= BUS_ADDR; // repeated start keeps the pointer
            {bit_cnt, ack_phase, sda_oe} <= '0;
         end else if (bus_stop) begin
            bus_state <= BUS_IDLE;
            {ack_phase, sda_oe} <= '0;
         end else if (scl_rise && bus_state != BUS_IDLE && !ack_phase) begin
            if (bus_state == BUS_RDATA && bit_cnt == 4'd8) begin
               if (sda_s) bus_state <= BUS_IDLE; // host nack ends the read
               else ack_phase <= 1'b1;
            end else begin
               if (bus_state != BUS_RDATA) shift_reg <= {shift_reg[6:0], sda_s};
               bit_cnt <= bit_cnt + 4'd1;
            end
         end else if (scl_fall && bus_state != BUS_IDLE) begin
            if (ack_phase) begin
               ack_phase <= 1'b0;
               bit_cnt <= '0;
               if (bus_state == BUS_RDATA) begin
                  shift_reg <= {rd_byte[6:0], 1'b0};
                  sda_oe <= !rd_byte[7];
                  ptr_reg <= ptr_reg + 8'd1;
               end else begin
                  sda_oe <= 1'b0;
               end
            end else if (bus_state == BUS_RDATA) begin
               sda_oe <= bit_cnt != 4'd8 && !shift_reg[7];
               shift_reg <= {shift_reg[6:0], 1'b0};
            end else if (bit_cnt == 4'd8) begin
               ack_phase <= 1'b1;
               sda_oe <= 1'b1;
               if (bus_state == BUS_ADDR) begin
                  if (shift_reg[7:1] != DEV_ADDR) begin
                     bus_state <= BUS_IDLE;
                     {ack_phase, sda_oe} <= '0;
                  end else begin
                     bus_state <= shift_reg[0] ? BUS_RDATA : BUS_PTR;
                  end
               end else if (bus_state == BUS_PTR) begin
                  ptr_reg <= shift_reg;
                  bus_state <= BUS_WDATA;
               end else begin
                  wr_en <= 1'b1; // whole byte passed on; the pin register masks its reserved bits
                  wr_addr <= ptr_reg;
                  wr_data <= shift_reg;
                  ptr_reg <= ptr_reg + 8'd1;
               end
            end
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_pullup_write: assert property (wr_en && wr_addr == `ADDR_GLOBAL_CONFIG && pd_state == PD_IDLE
      |=> onkey_pullup_weak == $past(wr_data[7])) else $error("pull-up select not taken");
   a_bias_force_on: assert property (glb_reg.main_bias_force_on |=> main_bias_enable)
      else $error("bias not forced on");
   a_cmd_zero_idle: assert property (pd_state == PD_IDLE && wr_en && wr_addr == `ADDR_GLOBAL_CONFIG
      && wr_data[1:0] == 2'b00 |=> pd_state == PD_IDLE) else $error("null command acted");
   a_seq_reset_out: assert property ($rose(pd_state == PD_RST) |-> !reset_output_low && regulators_on)
      else $error("reset output not asserted");
   a_ship_switch: assert property (pd_state == PD_SHIP |-> battery_switch_open && !regulators_on)
      else $error("ship mode switch closed");
   a_pin_alt_out: assert property (pin_reg.pin0_alternate_function
      |=> pin0_oe && pin0_out == $past(buck_boost_rail_two)) else $error("alternate output wrong");
   a_pin_open_float: assert property (!pin_reg.pin0_alternate_function && !pin_reg.pin_direction_input
      && pin_reg.pin_output_value && !pin_reg.pin_driver_type |=> !pin0_oe) else $error("open drain drives high");
   a_pin_input_off: assert property (!pin_reg.pin0_alternate_function && pin_reg.pin_direction_input
      |=> !pin0_oe) else $error("input pin driven");
   a_pin_no_debounce: assert property (!pin_reg.pin_input_debounce_enable
      ##1 !pin_reg.pin_input_debounce_enable |-> pin0_level == $past(pin_s)) else $error("pin level delayed");
   a_onkey_status: assert property (onkey_level |=> !onkey_active) else $error("on-key status wrong");
endmodule : global_pin0_config

// [global_pin0_consts.svh]
`ifndef GLOBAL_PIN0_CONSTS_SVH
`define GLOBAL_PIN0_CONSTS_SVH
// register offsets
`define ADDR_GLOBAL_CONFIG 8'h10
`define ADDR_PIN0_CONFIG 8'h11
`define ADDR_WIDTH 8
// field positions and fixed reset values
`define PIN_DIN_BIT 1
`define PIN_RSVD_MASK 8'h3d
`define RST_PULLUP_WEAK 1'b0
`define RST_BIAS_FORCE 1'b0
`define RST_POWER_CMD 2'b00
`define RST_PIN_DEB 1'b0
`define RST_PIN_DOUT 1'b0
`define RST_PIN_DRIVER 1'b0
`define RST_PIN_DIR_INPUT 1'b1
`define RST_DEV_ADDR 7'h48
// timing: clock, base tick and documented times in microseconds
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_US 10
`define TICK_CYCLES (`TICK_PERIOD_US * 1000 / `CLK_PERIOD_NS)
`define TIMER_W 21
`define US_TO_TICKS(t) (((t) + `TICK_PERIOD_US - 1) / `TICK_PERIOD_US)
`define T_ONKEY_DEB_SHORT_US 500
`define T_DEB_LONG_US 30000
`define T_KEYHOLD_SHORT_US 8000000
`define T_KEYHOLD_LONG_US 16000000
`define T_PD_INIT_US 60000
`define T_PD_RST_US 10240
`define T_PD_SLOT_US 2560
`define T_PD_DISCHARGE_US 125000
`define PD_SLOT_COUNT 4
`endif

// [global_pin0_pkg.sv]
package global_pin0_pkg;
   typedef struct packed {
      logic onkey_pullup_weak_select;
      logic manual_reset_duration_select;
      logic main_bias_lowpower_request;
      logic main_bias_force_on;
      logic onkey_input_style;
      logic onkey_debounce_select;
      logic [1:0] software_power_command;
   } global_cfg_t;
   typedef struct packed {
      logic [1:0] reserved;
      logic pin0_alternate_function;
      logic pin_input_debounce_enable;
      logic pin_output_value;
      logic pin_driver_type;
      logic pin_input_value;
      logic pin_direction_input;
   } pin_cfg_t;
   typedef struct packed {
      logic manual_reset_duration_select;
      logic main_bias_lowpower_request;
      logic onkey_input_style;
      logic onkey_debounce_select;
      logic pin0_alternate_function;
   } factory_t;
   typedef enum logic [1:0] {CMD_NONE, CMD_COLD_RESTART, CMD_POWER_OFF, CMD_FACTORY_SHIP} power_cmd_t;
   typedef enum {PD_IDLE, PD_INIT, PD_RST, PD_SLOT, PD_DISCHARGE, PD_OFF, PD_SHIP} pd_state_t;
   typedef enum {BUS_IDLE, BUS_ADDR, BUS_PTR, BUS_WDATA, BUS_RDATA} bus_state_t;
endpackage : global_pin0_pkg

// [serial_host.sv]
`timescale 1ns/10ps
// serial host; clock rests high and data is released between frames
module serial_host #(
   parameter logic [6:0] DEV_ADDR = 7'h48 // arbitrary value
) (
   input wire logic core_clk, // bench clock
   input wire logic sda, // resolved data line
   output logic scl = 1'b1, // serial clock
   output logic sda_low = 1'b0 // pull data low
);
   logic [8:0] r0, r1, r2, r3;
   // each phase holds 8 cycles, above the 5-cycle minimum
   task half();
      repeat (8) @(negedge core_clk);
   endtask : half
   // start when to_low, stop otherwise; data never moves with a clock edge
   task cond(input logic to_low);
      half();
      sda_low = !to_low;
      half();
      scl = 1'b1;
      half();
      sda_low = to_low;
      half();
      if (to_low) scl = 1'b0;
   endtask : cond
   // one bit each way, data set well after the clock fell
   task xfer(input logic b, output logic r);
      half();
      sda_low = !b;
      half();
      scl = 1'b1;
      half();
      r = sda;
      scl = 1'b0;
   endtask : xfer
   // most significant bit first, then the acknowledge slot released
   task xbyte(input logic [7:0] b, output logic [8:0] r);
      logic [8:0] w;
      w = {b, 1'b1};
      for (int i = 8; i >= 0; i--) xfer(w[i], r[i]);
   endtask : xbyte
   task write(input logic [7:0] a, input logic [7:0] d, output logic ok);
      cond(1'b1);
      xbyte({DEV_ADDR, 1'b0}, r0);
      xbyte(a, r1);
      xbyte(d, r2);
      cond(1'b0);
      ok = !(r0[0] | r1[0] | r2[0]);
   endtask : write
   // pointer write, repeated start, one byte ended by a refusal
   task read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      cond(1'b1);
      xbyte({DEV_ADDR, 1'b0}, r0);
      xbyte(a, r1);
      cond(1'b1);
      xbyte({DEV_ADDR, 1'b1}, r2);
      xbyte(8'hff, r3);
      cond(1'b0);
      d = r3[8:1];
      ok = !(r0[0] | r1[0] | r2[0]);
   endtask : read
endmodule : serial_host

// [tb.sv]
`timescale 1ns/10ps
module tb;
   import global_pin0_pkg::*;
   logic core_clk = 0, sys_rst = 1, key_in_low = 1, oba = 0, wake = 0, shipx = 0, bb2 = 0, ext = 1;
   logic sda_oe, sda_out, pu_w, slide, key_act, mrst, b_en, b_lp, rst_out_low, reg_on, disch, bsw;
   logic scl, sda_low, p_out, p_oe, p_lvl, ok, eoe, eout;
   factory_t f = '0;
   logic [7:0] d, g, e;
   int fail_count = 0, total_checks = 0, n;
   // both wires resolved from every driver; data has a pull-up
   wire logic sda = sda_oe ? sda_out : !sda_low;
   wire logic pin0 = p_oe ? p_out : ext;
   // scaled times in ticks; the waits below are worked out from these
   localparam int KEY_TICKS = 2, LONG_TICKS = 3, HOLD_S = 4, HOLD_L = 5;
   // power-down phases, reset-low and slot phases of equal length; the four slots are timed together in one wait
   localparam int INIT_TICKS = 3, LOW_TICKS = 2, SLOT_TICKS = 2, DISCH_TICKS = 4;
   global_pin0_config #(.ONKEY_DEB_SHORT(21'(KEY_TICKS)), .DEB_LONG(21'(LONG_TICKS)), .MRST_SHORT(21'(HOLD_S)),
      .MRST_LONG(21'(HOLD_L)), .PD_INIT_TICKS(21'(INIT_TICKS)), .PD_RST_TICKS(21'(LOW_TICKS)),
      .PD_SLOT_TICKS(21'(SLOT_TICKS)), .PD_DISCH_TICKS(21'(DISCH_TICKS)))
   global_pin0_config_inst (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .factory_cfg(f), .onkey_input(key_in_low), .onkey_pullup_weak(pu_w),
      .onkey_style_slide(slide), .onkey_active(key_act), .manual_reset_request(mrst), .onoff_bias_request(oba),
      .main_bias_enable(b_en), .main_bias_lowpower(b_lp), .wake_event(wake), .ship_exit_event(shipx),
      .reset_output_low(rst_out_low), .regulators_on(reg_on), .output_discharge(disch),
      .battery_switch_open(bsw), .buck_boost_rail_two(bb2), .pin0_in(pin0), .pin0_out(p_out), .pin0_oe(p_oe),
      .pin0_level(p_lvl));
   serial_host host_inst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   initial forever #5 core_clk = ~core_clk;
   task results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   // wait for a level; too early or past t+2 ticks is a mismatch
   // the early bound allows for the host's stop tail after a command write
   task automatic step(ref logic s, input logic v, input int tk);
      n = 0;
      while (s !== v && n < (tk + 2) * 1000) begin
         @(negedge core_clk);
         n++;
      end
      chk({7'h0, s === v && n >= (tk - 1) * 1000 - 100}, 8'h1);
      if (s !== v) results();
   endtask : step
   task wr(input logic [7:0] a, input logic [7:0] v);
      host_inst.write(a, v, ok);
      chk({7'h0, ok}, 8'h1);
   endtask : wr
   task rd(input logic [7:0] a);
      host_inst.read(a, d, ok);
      chk({7'h0, ok}, 8'h1);
   endtask : rd
   initial begin
      void'($urandom(36085));
      f = 5'($urandom);
      repeat (16) @(negedge core_clk);
      sys_rst = 0;
      // reset values under random factory settings
      rd(8'h10);
      chk(d, {1'b0, f[4:3], 1'b0, f[2:1], 2'h0});
      rd(8'h11);
      // in alternate mode the pin shows the idle rail enable, low
      chk(d & 8'h3f, {2'h0, f[0], 3'h0, !f[0], 1'b1});
      // unmapped place: write dropped, read zero
      wr(8'h20, 8'h5a);
      rd(8'h20);
      chk(d, 8'h00);
      // global fields with the command left at zero
      repeat (3) begin
         g = 8'($urandom) & 8'hfc;
         oba = 1'($urandom);
         wr(8'h10, g);
         rd(8'h10);
         chk(d, g);
         chk({4'h0, pu_w, slide, b_lp, b_en}, {4'h0, g[7], g[3], g[5], g[4] | oba});
      end
      // every pin 0 mode, random wire level and rail enable
      for (int i = 0; i < 16; i++) begin
         e = {2'h0, i[3], 1'b0, i[2:1], 1'b0, i[0]};
         ext = 1'($urandom);
         bb2 = 1'($urandom);
         wr(8'h11, e);
         rd(8'h11);
         eoe = i[3] | (!i[0] & (!i[2] | i[1]));
         eout = i[3] ? bb2 : i[2];
         chk({6'h0, p_oe, p_oe & p_out}, {6'h0, eoe, eoe & eout});
         chk(d, e | {6'h0, eoe ? eout : ext, 1'b0});
         chk({7'h0, p_lvl}, {7'h0, eoe ? eout : ext});
      end
      // long pin filter, scaled to three ticks
      wr(8'h11, 8'h11);
      ext = p_lvl;
      repeat (10) @(negedge core_clk);
      ext = !ext;
      step(p_lvl, ext, LONG_TICKS);
      // key press: filter per bit 2, held-key reset per bit 6
      key_in_low = 0;
      step(key_act, 1'b1, g[2] ? LONG_TICKS : KEY_TICKS);
      step(mrst, 1'b1, g[6] ? HOLD_L : HOLD_S);
      key_in_low = 1;
      // cold restart runs the ordered power-down and comes back reset
      wr(8'h10, 8'h01);
      step(rst_out_low, 1'b0, INIT_TICKS);
      step(reg_on, 1'b0, LOW_TICKS);
      step(disch, 1'b1, 4 * SLOT_TICKS);
      step(disch, 1'b0, DISCH_TICKS);
      step(reg_on, 1'b1, 0);
      step(rst_out_low, 1'b1, 0);
      repeat (1000) @(negedge core_clk);
      rd(8'h10);
      chk(d, {1'b0, f[4:3], 1'b0, f[2:1], 2'h0});
      // power off stays down until woken
      wr(8'h10, 8'h02);
      step(disch, 1'b1, INIT_TICKS + LOW_TICKS + 4 * SLOT_TICKS);
      step(disch, 1'b0, DISCH_TICKS);
      repeat (3000) @(negedge core_clk);
      chk({7'h0, reg_on}, 8'h0);
      wake = 1;
      @(negedge core_clk);
      wake = 0;
      step(reg_on, 1'b1, 0);
      repeat (1000) @(negedge core_clk);
      // factory ship opens the battery switch until its exit event
      wr(8'h10, 8'h03);
      step(bsw, 1'b1, 0);
      chk({7'h0, reg_on}, 8'h0);
      // ship entry also returns the configuration to its reset values
      rd(8'h10);
      chk(d, {1'b0, f[4:3], 1'b0, f[2:1], 2'h0});
      shipx = 1;
      @(negedge core_clk);
      shipx = 0;
      step(bsw, 1'b0, 0);
      results();
   end
endmodule : tb
